// ### rtl/pic_pkg.sv
// Package for the priority interrupt controller: field layout, codes, vectors
package pic_pkg;
   // Source indices, also the index used by the clear operation
   localparam int NUM_SRC = 5;
   localparam logic [2:0] SRC_EXT = 3'h0;
   localparam logic [2:0] SRC_ADC = 3'h1;
   localparam logic [2:0] SRC_SER = 3'h2;
   localparam logic [2:0] SRC_TMR = 3'h3;
   localparam logic [2:0] SRC_PWR = 3'h4;
   // Field positions in source_mask_and_edge
   localparam int MASK_EXT_BIT = 0;
   localparam int MASK_ADC_BIT = 1;
   localparam int MASK_SER_BIT = 2;
   localparam int MASK_TMR_BIT = 3;
   localparam int MASK_PWR_BIT = 4;
   localparam int EDGE_SEL_BIT = 7;
   localparam logic [7:0] MASK_REG_USED = 8'h9F;
   // Peripheral codes in peripheral_priority_map slots
   localparam logic [1:0] CODE_ADC = 2'h0;
   localparam logic [1:0] CODE_SER = 2'h1;
   localparam logic [1:0] CODE_TMR = 2'h2;
   localparam logic [1:0] CODE_PWR = 2'h3;
   // Reset values
   localparam logic [7:0] MASK_REG_RESET = 8'h00;
   localparam logic [7:0] PRIO_REG_RESET = 8'hE4;
   // Priority levels
   localparam logic [2:0] LEVEL_EXT = 3'h0;
   localparam logic [2:0] LEVEL_MAIN = 3'h5;
   // Vector byte addresses (low byte of each two-byte vector)
   localparam logic [7:0] VEC_EXT = 8'hC8;
   localparam logic [7:0] VEC_ADC = 8'hC0;
   localparam logic [7:0] VEC_SER = 8'hC2;
   localparam logic [7:0] VEC_TMR = 8'hC4;
   localparam logic [7:0] VEC_PWR = 8'hC6;
   // Level stack depth (one entry per priority level, 0 to 5)
   localparam int STACK_DEPTH = 6;
endpackage

// ### rtl/pic_level_map.sv
// Maps a pending set to the winning source and its priority level
`timescale 1ns/100ps
module pic_level_map (
   input wire logic [4:0] req_in,
   input wire logic [7:0] prio_map_in,
   output logic [2:0] src_out,
   output logic [2:0] level_out,
   output logic valid_out
);
   // Peripheral code to source index, slots scanned high to low
   function automatic logic [2:0] code_to_src(input logic [1:0] code);
      unique case (code)
         pic_pkg::CODE_ADC: code_to_src = pic_pkg::SRC_ADC;
         pic_pkg::CODE_SER: code_to_src = pic_pkg::SRC_SER;
         pic_pkg::CODE_TMR: code_to_src = pic_pkg::SRC_TMR;
         pic_pkg::CODE_PWR: code_to_src = pic_pkg::SRC_PWR;
      endcase
   endfunction

   // External first at level 0, then slots for levels 1..4
   always_comb begin
      logic [2:0] s;
      s = 3'h0;
      src_out = pic_pkg::SRC_EXT;
      level_out = pic_pkg::LEVEL_MAIN;
      valid_out = 1'b0;
      for (int lv = 4; lv >= 1; lv--) begin
         s = code_to_src(prio_map_in[2*(lv-1) +: 2]);
         if (req_in[s]) begin
            src_out = s;
            level_out = 3'(lv);
            valid_out = 1'b1;
         end
      end
      if (req_in[pic_pkg::SRC_EXT]) begin
         src_out = pic_pkg::SRC_EXT;
         level_out = pic_pkg::LEVEL_EXT;
         valid_out = 1'b1;
      end
   end
endmodule // pic_level_map

// ### rtl/pic_ctrl.sv
// Priority interrupt controller: pending flags, masking, levels, vector hand-off
//
// Behaviour
// - Requests come from the external pin and from ADC, serial port, timer and power driver.
// - Bit 7 of the mask register picks the external edge, 0 rising and 1 falling.
// - A mask bit of 1 enables its source; a 0 masks it but its request stays pending.
// - Mask bits are 0 external, 1 converter, 2 serial, 3 timer, 4 power driver; 5 and 6 unused.
// - Six priority levels exist, 0 most urgent and 5 least.
// - Level 5 is the main program, level 0 the external source, levels 1 to 4 mapped.
// - Peripheral codes are converter 00, serial 01, timer 10, power driver 11.
// - The priority map holds four two-bit slots for levels 1 (bits 1:0) to 4 (bits 7:6).
// - Flow is diverted only when a source requests and its handling is enabled.
// - A taken request yields the vector address of that source.
// - After service, execution resumes after the interrupted instruction.
// - A clear operation by source index cancels just that source's pending request.
// - Requests are taken only at an evaluation point, never inside fuzzy rule processing.
// - A more urgent request preempts a running routine; return restores the prior level.
// - A global request needs both the user and the macro global masks open.
`timescale 1ns/100ps
module pic_ctrl (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic ext_pin_in,
   input wire logic converter_request_in,
   input wire logic serial_port_request_in,
   input wire logic timer_request_in,
   input wire logic power_driver_request_in,
   input wire logic config_load_op_in,
   input wire logic config_sel_in,
   input wire logic [7:0] config_data_in,
   input wire logic pending_clear_op_in,
   input wire logic [2:0] pending_clear_idx_in,
   input wire logic user_global_unmask_in,
   input wire logic user_global_mask_set_in,
   input wire logic macro_global_unmask_in,
   input wire logic macro_global_mask_set_in,
   input wire logic eval_point_in,
   input wire logic return_from_service_in,
   output logic [7:0] source_mask_and_edge_out,
   output logic [7:0] peripheral_priority_map_out,
   output logic [4:0] pending_out,
   output logic global_pending_out,
   output logic global_request_out,
   output logic take_out,
   output logic [7:0] vector_addr_out,
   output logic [2:0] take_src_out,
   output logic [2:0] current_level_out,
   output logic resume_out
);
   // Configuration registers
   logic [7:0] mask_q, mask_d;
   logic [7:0] prio_q, prio_d;
   // Pending, edge history, global masks
   logic [4:0] pend_q, pend_d;
   logic ext_prev_q, ext_prev_d;
   logic user_en_q, user_en_d;
   logic macro_en_q, macro_en_d;
   // Level stack of preempted levels
   logic [2:0] level_q, level_d;
   logic [2:0] stack_q [pic_pkg::STACK_DEPTH];
   logic [2:0] stack_d [pic_pkg::STACK_DEPTH];
   logic [2:0] sp_q, sp_d;
   // Hand-off outputs
   logic take_q, take_d;
   logic [7:0] vec_q, vec_d;
   logic [2:0] tsrc_q, tsrc_d;
   logic resume_q, resume_d;

   logic [4:0] raw_req;
   logic [4:0] enabled;
   logic [4:0] mask_bits;
   logic ext_event;
   logic [2:0] win_src;
   logic [2:0] win_level;
   logic win_valid;
   logic global_pending;
   logic global_request;

   // Edge on the external pin, polarity chosen by software
   assign ext_event = mask_q[pic_pkg::EDGE_SEL_BIT] ?
                      (ext_prev_q & ~ext_pin_in) : (~ext_prev_q & ext_pin_in);
   // Peripherals raise a line only when configured to; taken as one-cycle events
   assign raw_req = {power_driver_request_in, timer_request_in, serial_port_request_in,
                     converter_request_in, ext_event};
   assign mask_bits = {mask_q[pic_pkg::MASK_PWR_BIT], mask_q[pic_pkg::MASK_TMR_BIT],
                       mask_q[pic_pkg::MASK_SER_BIT], mask_q[pic_pkg::MASK_ADC_BIT],
                       mask_q[pic_pkg::MASK_EXT_BIT]};
   // Masked sources stay pending but do not compete
   assign enabled = pend_q & mask_bits;

   pic_level_map u_pic_level_map (
      .req_in(enabled),
      .prio_map_in(prio_q),
      .src_out(win_src),
      .level_out(win_level),
      .valid_out(win_valid)
   );

   // Only a source more urgent than the running level may be passed
   // Equal levels wait, so a routine can never preempt itself
   assign global_pending = win_valid && (win_level < level_q);
   assign global_request = global_pending && user_en_q && macro_en_q;

   // Vector address lookup for the winning source
   function automatic logic [7:0] vec_of(input logic [2:0] src);
      unique case (src)
         pic_pkg::SRC_EXT: vec_of = pic_pkg::VEC_EXT;
         pic_pkg::SRC_ADC: vec_of = pic_pkg::VEC_ADC;
         pic_pkg::SRC_SER: vec_of = pic_pkg::VEC_SER;
         pic_pkg::SRC_TMR: vec_of = pic_pkg::VEC_TMR;
         default: vec_of = pic_pkg::VEC_PWR;
      endcase
   endfunction

   // Next-state of configuration and global masks
   always_comb begin
      mask_d = mask_q;
      prio_d = prio_q;
      // Writes to unused bits 6:5 are dropped so they always read as zero
      if (config_load_op_in && !config_sel_in) begin
         mask_d = config_data_in & pic_pkg::MASK_REG_USED;
      end
      if (config_load_op_in && config_sel_in) begin
         prio_d = config_data_in;
      end
      user_en_d = user_en_q;
      if (user_global_unmask_in) user_en_d = 1'b1;
      if (user_global_mask_set_in) user_en_d = 1'b0;
      macro_en_d = macro_en_q;
      if (macro_global_unmask_in) macro_en_d = 1'b1;
      if (macro_global_mask_set_in) macro_en_d = 1'b0;
      ext_prev_d = ext_pin_in;
   end

   // Next-state of pending flags, level stack and hand-off
   always_comb begin
      logic taking;
      taking = eval_point_in && global_request;
      pend_d = pend_q;
      level_d = level_q;
      sp_d = sp_q;
      stack_d = stack_q;
      take_d = 1'b0;
      vec_d = vec_q;
      tsrc_d = tsrc_q;
      resume_d = 1'b0;
      // Clear by index, then service; a new event wins over both
      if (pending_clear_op_in && pending_clear_idx_in < 3'(pic_pkg::NUM_SRC)) begin
         pend_d[pending_clear_idx_in] = 1'b0;
      end
      // Six entries suffice: every push is strictly more urgent than the last
      // A return in the cycle of a take is dropped; the control unit must repeat it
      if (taking) begin
         pend_d[win_src] = 1'b0;
         stack_d[sp_q] = level_q;
         sp_d = sp_q + 3'h1;
         level_d = win_level;
         take_d = 1'b1;
         vec_d = vec_of(win_src);
         tsrc_d = win_src;
      end else if (return_from_service_in && sp_q != 3'h0) begin
         sp_d = sp_q - 3'h1;
         level_d = stack_q[sp_q - 3'h1];
         resume_d = 1'b1;
      end
      pend_d = pend_d | raw_req;
   end

   // Register configuration, global masks and pin history
   // Macro mask starts open so only the user mask gates requests after reset
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         mask_q <= pic_pkg::MASK_REG_RESET;
         prio_q <= pic_pkg::PRIO_REG_RESET;
         ext_prev_q <= 1'b0;
         user_en_q <= 1'b0;
         macro_en_q <= 1'b1;
      end else begin
         mask_q <= mask_d;
         prio_q <= prio_d;
         ext_prev_q <= ext_prev_d;
         user_en_q <= user_en_d;
         macro_en_q <= macro_en_d;
      end
   end

   // Register pending flags, level stack and hand-off
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         pend_q <= 5'h00;
         level_q <= pic_pkg::LEVEL_MAIN;
         sp_q <= 3'h0;
         for (int i = 0; i < pic_pkg::STACK_DEPTH; i++) stack_q[i] <= pic_pkg::LEVEL_MAIN;
         take_q <= 1'b0;
         vec_q <= 8'h00;
         tsrc_q <= 3'h0;
         resume_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
         level_q <= level_d;
         sp_q <= sp_d;
         stack_q <= stack_d;
         take_q <= take_d;
         vec_q <= vec_d;
         tsrc_q <= tsrc_d;
         resume_q <= resume_d;
      end
   end

   // Outputs
   assign source_mask_and_edge_out = mask_q;
   assign peripheral_priority_map_out = prio_q;
   assign pending_out = pend_q;
   assign global_pending_out = global_pending;
   assign global_request_out = global_request;
   assign take_out = take_q;
   assign vector_addr_out = vec_q;
   assign take_src_out = tsrc_q;
   assign current_level_out = level_q;
   assign resume_out = resume_q;
endmodule // pic_ctrl

// ### tb/pic_cu_model.sv
// Control unit and peripheral request lines facing the controller
`timescale 1ns/100ps
module pic_control_unit_model (
   input wire logic clock_in,
   output logic [5:0] strobe_out
);
   // Bits 0-3 adc, serial, timer, power requests 4 evaluation point 5 return
   initial begin
      strobe_out = 6'h00;
   end
   // Each strobe stands one cycle, so a level never piles up extra pending events
   task automatic strobe(input int idx);
      @(posedge clock_in);
      strobe_out[idx] <= 1'b1;
      @(posedge clock_in);
      strobe_out <= 6'h00;
   endtask
endmodule // pic_control_unit_model

// ### tb/pic_ctrl_properties.sv
// Concurrent checks on the controller ports
`timescale 1ns/100ps
module pic_ctrl_properties (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic converter_request_in,
   input wire logic pending_clear_op_in,
   input wire logic [2:0] pending_clear_idx_in,
   input wire logic serial_port_request_in,
   input wire logic eval_point_in,
   input wire logic return_from_service_in,
   input wire logic user_global_mask_set_in,
   input wire logic macro_global_mask_set_in,
   input wire logic [7:0] source_mask_and_edge_out,
   input wire logic [4:0] pending_out,
   input wire logic global_pending_out,
   input wire logic global_request_out,
   input wire logic take_out,
   input wire logic [7:0] vector_addr_out,
   input wire logic [2:0] take_src_out,
   input wire logic [2:0] current_level_out,
   input wire logic resume_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   take_cause_a: assert property (take_out |->
      $past(eval_point_in) && $past(global_request_out))
      else $error("take without evaluation point");
   take_due_a: assert property (eval_point_in && global_request_out |=> take_out)
      else $error("request not taken");
   vector_map_a: assert property (take_out |-> vector_addr_out ==
      ((take_src_out == 3'h0) ? 8'hC8 : 8'hBE + {4'h0, take_src_out, 1'b0}))
      else $error("wrong vector");
   ext_level_a: assert property (take_out && take_src_out == 3'h0 |->
      current_level_out == 3'h0)
      else $error("external not at top level");
   serviced_level_a: assert property (take_out |-> current_level_out < 3'h5)
      else $error("service at main level");
   global_gate_a: assert property (global_request_out |->
      global_pending_out && current_level_out != 3'h0)
      else $error("request without pending");
   masked_request_a: assert property (user_global_mask_set_in || macro_global_mask_set_in
      |=> !global_request_out)
      else $error("request while globally masked");
   pending_set_a: assert property (converter_request_in |=> pending_out[1])
      else $error("converter event lost");
   clear_one_a: assert property (pending_clear_op_in && pending_clear_idx_in == 3'h2 &&
      !serial_port_request_in |=> !pending_out[2])
      else $error("serial pending not cleared");
   resume_cause_a: assert property (resume_out |-> $past(return_from_service_in))
      else $error("resume without return");
   unused_bits_a: assert property (source_mask_and_edge_out[6:5] == 2'b00)
      else $error("unused mask bits set");
   cover property (take_out && take_src_out == 3'h0);
   cover property (resume_out);
   cover property (take_out && current_level_out == 3'h1);
endmodule // pic_ctrl_properties

// ### tb/pic_ctrl_tb.sv
// Self-checking bench for the priority interrupt controller
`timescale 1ns/100ps
module pic_ctrl_tb;
   logic clock_in, rst_n_in, ext_pin_in, config_load_op_in, config_sel_in, pending_clear_op_in;
   logic user_global_unmask_in, user_global_mask_set_in, macro_global_unmask_in;
   logic macro_global_mask_set_in, global_pending_out, global_request_out, take_out, resume_out;
   logic [7:0] config_data_in, source_mask_and_edge_out, peripheral_priority_map_out;
   logic [7:0] vector_addr_out;
   logic [2:0] pending_clear_idx_in, take_src_out, current_level_out;
   logic [4:0] pending_out;
   logic [5:0] strobe;
   wire logic converter_request_in = strobe[0];
   wire logic serial_port_request_in = strobe[1];
   wire logic timer_request_in = strobe[2];
   wire logic power_driver_request_in = strobe[3];
   wire logic eval_point_in = strobe[4];
   wire logic return_from_service_in = strobe[5];
   int mismatches = 0;
   int check_count = 0;
   pic_control_unit_model u_pic_control_unit_model (.clock_in(clock_in), .strobe_out(strobe));
   pic_ctrl u_pic_ctrl (.clock_in, .rst_n_in, .ext_pin_in, .converter_request_in,
      .serial_port_request_in, .timer_request_in, .power_driver_request_in, .config_load_op_in,
      .config_sel_in, .config_data_in, .pending_clear_op_in, .pending_clear_idx_in,
      .user_global_unmask_in, .user_global_mask_set_in, .macro_global_unmask_in,
      .macro_global_mask_set_in, .eval_point_in, .return_from_service_in,
      .source_mask_and_edge_out, .peripheral_priority_map_out, .pending_out, .global_pending_out,
      .global_request_out, .take_out, .vector_addr_out, .take_src_out, .current_level_out,
      .resume_out);
   // 50 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle configuration write, read back one cycle later
   task automatic cfg(input logic sel, input logic [7:0] data);
      @(posedge clock_in);
      {config_load_op_in, config_sel_in, config_data_in} <= {1'b1, sel, data};
      @(posedge clock_in);
      config_load_op_in <= 1'b0;
      #1;
   endtask
   // Global mask pulses: user unmask, user set, macro unmask, macro set
   task automatic gctl(input logic [3:0] v);
      @(posedge clock_in);
      {user_global_unmask_in, user_global_mask_set_in, macro_global_unmask_in,
         macro_global_mask_set_in} <= v;
      @(posedge clock_in);
      {user_global_unmask_in, user_global_mask_set_in, macro_global_unmask_in,
         macro_global_mask_set_in} <= 4'h0;
      #1;
   endtask
   task automatic act(input int idx);
      u_pic_control_unit_model.strobe(idx);
      #1;
   endtask
   task automatic took(input logic [7:0] vec, input logic [2:0] lvl, input logic [2:0] src);
      chk({7'h00, take_out}, 8'h01);
      chk(vector_addr_out, vec);
      chk({5'h00, current_level_out}, {5'h00, lvl});
      chk({5'h00, take_src_out}, {5'h00, src});
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Main sequence; the controller is reset for 12 cycles first
   initial begin
      {rst_n_in, ext_pin_in, config_load_op_in, config_sel_in, pending_clear_op_in} = 5'h00;
      {user_global_unmask_in, user_global_mask_set_in} = 2'h0;
      {macro_global_unmask_in, macro_global_mask_set_in} = 2'h0;
      config_data_in = 8'h00;
      pending_clear_idx_in = 3'h0;
      repeat (12) @(posedge clock_in);
      rst_n_in <= 1'b1;
      #1;
      chk(source_mask_and_edge_out, pic_pkg::MASK_REG_RESET);
      chk({5'h00, current_level_out}, {5'h00, pic_pkg::LEVEL_MAIN});
      cfg(1'b1, 8'hC9);
      chk(peripheral_priority_map_out, 8'hC9);
      cfg(1'b0, 8'hFF);
      chk(source_mask_and_edge_out, 8'h9F);
      cfg(1'b0, 8'h00);
      gctl(4'h8);
      act(0);
      chk({3'h0, pending_out}, 8'h02);
      act(4);
      chk({7'h00, take_out}, 8'h00);
      cfg(1'b0, 8'h0E);
      act(4);
      took(pic_pkg::VEC_ADC, 3'h3, pic_pkg::SRC_ADC);
      act(1);
      act(4);
      took(pic_pkg::VEC_SER, 3'h1, pic_pkg::SRC_SER);
      act(2);
      act(4);
      chk({7'h00, take_out}, 8'h00);
      act(5);
      chk({6'h00, resume_out, current_level_out == 3'h3}, 8'h03);
      // Clear serial then timer back to back; each clear leaves the other flag alone
      act(1);
      @(posedge clock_in);
      {pending_clear_op_in, pending_clear_idx_in} <= {1'b1, pic_pkg::SRC_SER};
      @(posedge clock_in);
      pending_clear_idx_in <= pic_pkg::SRC_TMR;
      #1;
      chk({3'h0, pending_out}, 8'h08);
      @(posedge clock_in);
      pending_clear_op_in <= 1'b0;
      #1;
      chk({3'h0, pending_out}, 8'h00);
      act(5);
      cfg(1'b0, 8'h81);
      @(posedge clock_in);
      ext_pin_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      #1;
      chk({3'h0, pending_out}, 8'h00);
      @(posedge clock_in);
      ext_pin_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      #1;
      chk({3'h0, pending_out}, 8'h01);
      gctl(4'h1);
      chk({7'h00, global_request_out}, 8'h00);
      chk({7'h00, global_pending_out}, 8'h01);
      gctl(4'h2);
      act(4);
      took(pic_pkg::VEC_EXT, pic_pkg::LEVEL_EXT, pic_pkg::SRC_EXT);
      act(5);
      cfg(1'b0, 8'h10);
      act(3);
      act(4);
      took(pic_pkg::VEC_PWR, 3'h4, pic_pkg::SRC_PWR);
      // Rising edge selected again; a masked external event still stays pending
      @(posedge clock_in);
      ext_pin_in <= 1'b1;
      @(posedge clock_in);
      #1;
      chk({3'h0, pending_out}, 8'h01);
      complete_run();
   end
   // Watchdog well beyond the roughly 70 cycles the sequence needs
   initial begin
      repeat (3000) @(posedge clock_in);
      mismatches++;
      complete_run();
   end
endmodule // pic_ctrl_tb
bind pic_ctrl pic_ctrl_properties u_pic_ctrl_properties (.clock_in, .rst_n_in,
   .converter_request_in, .pending_clear_op_in, .pending_clear_idx_in, .serial_port_request_in,
   .eval_point_in, .return_from_service_in, .user_global_mask_set_in,
   .macro_global_mask_set_in, .source_mask_and_edge_out, .pending_out,
   .global_pending_out, .global_request_out, .take_out, .vector_addr_out, .take_src_out,
   .current_level_out, .resume_out);
